// ### csfu_top.sv
// Purpose: status flag unit of an 8-bit core with apb view
// Assumes: exec, halt, refresh and timeout come from pclk logic
// Notes: every output is registered
`timescale 1ns/1ps
`default_nettype none
`include "csfu_defines.svh"
module csfu_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`CSFU_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic exec_valid,
    input wire csfu_pkg::csfu_cls_t exec_cls,
    input wire logic [7:0] exec_opa,
    input wire logic [7:0] exec_opb,
    input wire logic halt_instr,
    input wire logic watchdog_refresh_instr,
    input wire logic watchdog_timeout,
    output logic [7:0] exec_result,
    output logic exec_done,
    output logic [7:0] flags,
    output logic irq
);
    import csfu_pkg::*;

    csfu_state_t st_reg;
    csfu_state_t st_next;

    logic [7:0] sum;
    logic c4;
    logic c7;
    logic c8;
    logic add_cin;
    logic [7:0] add_b;
    logic apb_take;
    logic apb_done;
    csfu_reg_t sel;
    logic [`CSFU_EV_W-1:0] ev_set;
    logic [`CSFU_EV_W-1:0] ev_clr;
    logic [`CSFU_EV_W-1:0] ev_status;
    logic ev_irq;
    logic [7:0] logic_res;
    logic zero_res;

    function automatic csfu_reg_t csfu_decode(input logic [`CSFU_AW-1:0] addr);
        csfu_reg_t r;
        case (addr)
            `CSFU_OFS_FLAGS: r = CSFU_R_FLAGS;
            `CSFU_OFS_EVST: r = CSFU_R_EVST;
            `CSFU_OFS_MASK: r = CSFU_R_MASK;
            `CSFU_OFS_RESULT: r = CSFU_R_RESULT;
            default: r = CSFU_R_NONE;
        endcase
        return r;
    endfunction : csfu_decode

    // status write keeps both system flags
    function automatic logic [7:0] csfu_merge(input logic [7:0] wr, input logic [7:0] old);
        return (wr & ~`CSFU_SYS_MASK) | (old & `CSFU_SYS_MASK);
    endfunction : csfu_merge

    csfu_add8 u_add (
        .a(exec_opa),
        .b(add_b),
        .cin(add_cin),
        .sum(sum),
        .c4(c4),
        .c7(c7),
        .c8(c8)
    );

    csfu_evt_ctrl #(
        .N(`CSFU_EV_W)
    ) u_evt (
        .pclk(pclk),
        .presetn(presetn),
        .ev_set(ev_set),
        .ev_clr(ev_clr),
        .ev_mask(st_reg.mask),
        .ev_status(ev_status),
        .irq(ev_irq)
    );

    assign sel = csfu_decode(paddr);
    assign apb_take = psel && penable && !st_reg.pready;
    assign apb_done = psel && penable && st_reg.pready;

    // adder operands: subtraction adds the inverted operand
    always_comb begin
        add_b = exec_opb;
        add_cin = 1'b0;
        case (exec_cls)
            CSFU_ADD: begin
                add_cin = 1'b0;
            end
            CSFU_ADD_CARRY: begin
                add_cin = st_reg.flags[`CSFU_BIT_CARRY];
            end
            CSFU_SUB: begin
                add_b = ~exec_opb;
                add_cin = 1'b1;
            end
            CSFU_SUB_BORROW: begin
                add_b = ~exec_opb;
                add_cin = st_reg.flags[`CSFU_BIT_CARRY];
            end
            default: begin
                add_b = exec_opb;
            end
        endcase
    end

    // logical operations
    always_comb begin
        case (exec_cls)
            CSFU_AND: logic_res = exec_opa & exec_opb;
            CSFU_OR: logic_res = exec_opa | exec_opb;
            CSFU_XOR: logic_res = exec_opa ^ exec_opb;
            default: logic_res = `CSFU_ZERO_BYTE;
        endcase
    end

    assign zero_res = (sum == `CSFU_ZERO_BYTE);

    always_comb begin
        st_next = st_reg;
        st_next.exec_done = 1'b0;
        st_next.pready = 1'b0;
        ev_set = '0;
        ev_clr = '0;

        // apb access phase: answer one cycle after penable rises
        if (apb_take) begin
            st_next.pready = 1'b1;
            st_next.pslverr = (sel == CSFU_R_NONE);
            st_next.prdata = '0;
            st_next.ev_rep = '0;
            if (!pwrite) begin
                case (sel)
                    CSFU_R_FLAGS: begin
                        st_next.prdata[7:0] = st_reg.flags;
                    end
                    CSFU_R_EVST: begin
                        st_next.prdata[`CSFU_EV_W-1:0] = ev_status;
                        st_next.ev_rep = ev_status;
                    end
                    CSFU_R_MASK: begin
                        st_next.prdata[`CSFU_EV_W-1:0] = st_reg.mask;
                    end
                    CSFU_R_RESULT: begin
                        st_next.prdata[7:0] = st_reg.result;
                    end
                    default: begin
                        st_next.prdata = '0;
                    end
                endcase
            end
        end

        // completing edge: writes commit, reported events clear
        if (apb_done) begin
            st_next.pslverr = 1'b0;
            if (!pwrite) begin
                ev_clr = st_reg.ev_rep;
            end else if (pstrb[0]) begin
                case (sel)
                    CSFU_R_FLAGS: begin
                        st_next.flags = csfu_merge(pwdata[7:0], st_reg.flags);
                    end
                    CSFU_R_MASK: begin
                        st_next.mask = pwdata[`CSFU_EV_W-1:0];
                    end
                    default: begin
                        st_next.mask = st_reg.mask;
                    end
                endcase
            end
        end

        // instruction results; flags not named keep their value
        // flags change only here, by apb or by system events
        if (exec_valid) begin
            st_next.exec_done = 1'b1;
            case (exec_cls)
                CSFU_ADD, CSFU_ADD_CARRY, CSFU_SUB, CSFU_SUB_BORROW: begin
                    st_next.result = sum;
                    st_next.flags[`CSFU_BIT_CARRY] = c8;
                    st_next.flags[`CSFU_BIT_NIBBLE] = c4;
                    st_next.flags[`CSFU_BIT_ZERO] = zero_res;
                    st_next.flags[`CSFU_BIT_RANGE] = c7 ^ c8;
                    st_next.flags[`CSFU_BIT_SIGNX] = c7 ^ c8 ^ sum[`CSFU_MSB];
                    ev_set[`CSFU_EV_RANGE] = c7 ^ c8;
                    if (exec_cls == CSFU_SUB) begin
                        st_next.flags[`CSFU_BIT_CHAIN] = zero_res;
                    end else if (exec_cls == CSFU_SUB_BORROW) begin
                        st_next.flags[`CSFU_BIT_CHAIN] =
                            st_reg.flags[`CSFU_BIT_CHAIN] & zero_res;
                    end
                end
                CSFU_AND, CSFU_OR, CSFU_XOR: begin
                    // carry, nibble and range keep their value
                    st_next.result = logic_res;
                    st_next.flags[`CSFU_BIT_ZERO] =
                        (logic_res == `CSFU_ZERO_BYTE);
                    st_next.flags[`CSFU_BIT_SIGNX] =
                        st_reg.flags[`CSFU_BIT_RANGE] ^ logic_res[`CSFU_MSB];
                end
                CSFU_RLC: begin
                    st_next.result = {exec_opa[6:0], st_reg.flags[`CSFU_BIT_CARRY]};
                    st_next.flags[`CSFU_BIT_CARRY] = exec_opa[`CSFU_MSB];
                end
                CSFU_RRC: begin
                    st_next.result = {st_reg.flags[`CSFU_BIT_CARRY], exec_opa[7:1]};
                    st_next.flags[`CSFU_BIT_CARRY] = exec_opa[0];
                end
                CSFU_WRST: begin
                    st_next.flags = csfu_merge(exec_opa, st_next.flags);
                end
                default: begin
                    st_next.result = st_reg.result;
                end
            endcase
        end

        // system flags; a time-out in the clearing cycle wins
        if (watchdog_refresh_instr) begin
            st_next.flags[`CSFU_BIT_HALT] = 1'b0;
            st_next.flags[`CSFU_BIT_WDOG] = 1'b0;
        end
        if (halt_instr) begin
            st_next.flags[`CSFU_BIT_HALT] = 1'b1;
            st_next.flags[`CSFU_BIT_WDOG] = 1'b0;
            ev_set[`CSFU_EV_HALT] = 1'b1;
        end
        if (watchdog_timeout) begin
            st_next.flags[`CSFU_BIT_WDOG] = 1'b1;
            ev_set[`CSFU_EV_WDOG] = 1'b1;
        end
    end

    // power-up clears both system flags
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '{
                flags: `CSFU_FLAGS_RST,
                result: `CSFU_RESULT_RST,
                exec_done: 1'b0,
                prdata: '0,
                pready: 1'b0,
                pslverr: 1'b0,
                mask: `CSFU_MASK_RST,
                ev_rep: '0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign exec_result = st_reg.result;
    assign exec_done = st_reg.exec_done;
    assign flags = st_reg.flags;
    assign irq = ev_irq;
endmodule : csfu_top
`default_nettype wire

// ### csfu_defines.svh
// Purpose: constants of the cpu status flag unit
// Assumes: included by the top module and the type package of the unit
// Notes: apb byte offsets, bit positions, reset values
`ifndef CSFU_DEFINES_SVH
`define CSFU_DEFINES_SVH

`define CSFU_AW 12
`define CSFU_OFS_FLAGS 12'h000
`define CSFU_OFS_EVST 12'h004
`define CSFU_OFS_MASK 12'h008
`define CSFU_OFS_RESULT 12'h00c

`define CSFU_BIT_CARRY 0
`define CSFU_BIT_NIBBLE 1
`define CSFU_BIT_ZERO 2
`define CSFU_BIT_RANGE 3
`define CSFU_BIT_HALT 4
`define CSFU_BIT_WDOG 5
`define CSFU_BIT_CHAIN 6
`define CSFU_BIT_SIGNX 7
`define CSFU_SYS_MASK 8'h30
`define CSFU_MSB 7

`define CSFU_EV_W 3
`define CSFU_EV_WDOG 0
`define CSFU_EV_HALT 1
`define CSFU_EV_RANGE 2

`define CSFU_FLAGS_RST 8'h00
`define CSFU_RESULT_RST 8'h00
`define CSFU_MASK_RST 3'h0
`define CSFU_ZERO_BYTE 8'h00

`endif

// ### csfu_pkg.sv
// Purpose: types of the cpu status flag unit
// Assumes: csfu_defines.svh gives widths
// Notes: instruction classes come from the execution datapath
`include "csfu_defines.svh"
package csfu_pkg;
    typedef enum logic [3:0] {
        CSFU_NOP,
        CSFU_ADD,
        CSFU_ADD_CARRY,
        CSFU_SUB,
        CSFU_SUB_BORROW,
        CSFU_AND,
        CSFU_OR,
        CSFU_XOR,
        CSFU_RLC,
        CSFU_RRC,
        CSFU_WRST
    } csfu_cls_t;

    typedef enum logic [2:0] {
        CSFU_R_FLAGS,
        CSFU_R_EVST,
        CSFU_R_MASK,
        CSFU_R_RESULT,
        CSFU_R_NONE
    } csfu_reg_t;

    typedef struct packed {
        logic [7:0] flags;
        logic [7:0] result;
        logic exec_done;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [`CSFU_EV_W-1:0] mask;
        logic [`CSFU_EV_W-1:0] ev_rep;
    } csfu_state_t;
endpackage : csfu_pkg

// ### csfu_add8.sv
// Purpose: 8-bit adder with nibble and msb carries
// Assumes: subtraction is fed as a plus inverted b
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
module csfu_add8 (
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    output logic [7:0] sum,
    output logic c4,
    output logic c7,
    output logic c8
);
    logic [4:0] lo;
    logic [3:0] mid;
    logic [1:0] top;

    always_comb begin
        lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        mid = {1'b0, a[6:4]} + {1'b0, b[6:4]} + {3'h0, lo[4]};
        top = {1'b0, a[7]} + {1'b0, b[7]} + {1'b0, mid[3]};
        sum = {top[0], mid[2:0], lo[3:0]};
        c4 = lo[4];
        c7 = mid[3];
        c8 = top[1];
    end
endmodule : csfu_add8
`default_nettype wire

// ### csfu_evt_ctrl.sv
// Purpose: sticky event bits, mask and interrupt level
// Assumes: clear vector holds only bits already reported
// Notes: a set in the clearing cycle wins
`timescale 1ns/1ps
`default_nettype none
module csfu_evt_ctrl #(
    parameter int N = 3
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [N-1:0] ev_set,
    input wire logic [N-1:0] ev_clr,
    input wire logic [N-1:0] ev_mask,
    output logic [N-1:0] ev_status,
    output logic irq
);
    typedef struct packed {
        logic [N-1:0] status;
        logic irq;
    } csfu_ev_state_t;

    csfu_ev_state_t st_reg;
    csfu_ev_state_t st_next;

    always_comb begin
        st_next.status = (st_reg.status & ~ev_clr) | ev_set;
        st_next.irq = |(st_next.status & ev_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign ev_status = st_reg.status;
    assign irq = st_reg.irq;
endmodule : csfu_evt_ctrl
`default_nettype wire

// ### csfu_top_sva.sv
// Purpose: port checker of the status flag unit
// Assumes: one pclk domain
// Notes: bound into csfu_top
`timescale 1ns/1ps
`default_nettype none
module csfu_top_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic exec_valid,
    input wire csfu_pkg::csfu_cls_t exec_cls,
    input wire logic [7:0] exec_opa,
    input wire logic [7:0] exec_opb,
    input wire logic halt_instr,
    input wire logic watchdog_refresh_instr,
    input wire logic watchdog_timeout,
    input wire logic [7:0] exec_result,
    input wire logic [7:0] flags
);
    import csfu_pkg::*;
    logic sys_ev;
    logic alu_op;
    assign sys_ev = halt_instr | watchdog_refresh_instr | watchdog_timeout;
    assign alu_op = exec_valid && (exec_cls inside {CSFU_ADD, CSFU_ADD_CARRY, CSFU_SUB,
        CSFU_SUB_BORROW, CSFU_AND, CSFU_OR, CSFU_XOR});
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sys_keep_a:
        assert property (!sys_ev |=> flags[5:4] == $past(flags[5:4]))
            else $error("sys flags moved");
    halt_set_a:
        assert property (halt_instr |=> flags[4]) else $error("halt flag not set");
    expiry_set_a:
        assert property (watchdog_timeout |=> flags[5]) else $error("expiry flag not set");
    zero_flag_a:
        assert property (alu_op |=> flags[2] == (exec_result == 8'h00)) else $error("zero flag");
    sign_xor_a:
        assert property (alu_op |=> flags[7] == (flags[3] ^ exec_result[7]))
            else $error("sign xor");
    carry_add_a:
        assert property (exec_valid && exec_cls == CSFU_ADD |=> flags[0] ==
            (({1'b0, $past(exec_opa)} + {1'b0, $past(exec_opb)}) > 9'h0ff)) else $error("carry");
    chain_keep_a:
        assert property (exec_valid && !(exec_cls inside {CSFU_SUB, CSFU_SUB_BORROW, CSFU_WRST})
            |=> $stable(flags[6])) else $error("chained zero moved");
    chain_and_a:
        assert property (exec_valid && exec_cls == CSFU_SUB_BORROW
            |=> flags[6] == ($past(flags[6]) & flags[2])) else $error("chained zero and");
    cover property (exec_valid && exec_cls == CSFU_SUB_BORROW);
    cover property (halt_instr);
    cover property (watchdog_timeout && !exec_valid);
endmodule : csfu_top_sva
bind csfu_top csfu_top_sva chk_u (.pclk(pclk), .presetn(presetn), .exec_valid(exec_valid),
    .exec_cls(exec_cls), .exec_opa(exec_opa), .exec_opb(exec_opb), .halt_instr(halt_instr),
    .watchdog_refresh_instr(watchdog_refresh_instr), .watchdog_timeout(watchdog_timeout),
    .exec_result(exec_result), .flags(flags));
`default_nettype wire

// ### csfu_exec_model.sv
// Purpose: execution datapath stand-in issuing instructions
// Assumes: the bench calls op
// Notes: released operands show their inverse
`timescale 1ns/1ps
`default_nettype none
module csfu_exec_model (
    input wire logic pclk,
    output logic exec_valid,
    output var csfu_pkg::csfu_cls_t exec_cls,
    output logic [7:0] exec_opa,
    output logic [7:0] exec_opb,
    output logic [2:0] sys
);
    import csfu_pkg::*;
    initial begin
        exec_valid = 1'b0;
        exec_cls = CSFU_NOP;
        exec_opa = 8'h00;
        exec_opb = 8'h00;
        sys = 3'h0;
    end
    task automatic op(input logic v, input csfu_cls_t c, input logic [7:0] a, input logic [7:0] b,
        input logic [2:0] s);
        @(posedge pclk);
        exec_valid <= v;
        exec_cls <= c;
        exec_opa <= a;
        exec_opb <= b;
        sys <= s;
        @(posedge pclk);
        exec_valid <= 1'b0;
        exec_opa <= ~a;
        exec_opb <= ~b;
        sys <= 3'h0;
    endtask : op
endmodule : csfu_exec_model
`default_nettype wire

// ### csfu_top_tb.sv
// Purpose: self-checking bench of the status flag unit
// Assumes: apb master and flag model in the bench
// Notes: sys bits are timeout, refresh, halt
`timescale 1ns/1ps
`default_nettype none
module csfu_top_tb;
    import csfu_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, exec_valid, exec_done, irq, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] exec_opa, exec_opb, exec_result, flags, mf, mres;
    logic [2:0] sys;
    logic [3:0] pstrb;
    csfu_cls_t exec_cls;
    int bad_count, tests_run, seed, s;
    csfu_exec_model exec_u (.pclk(pclk), .exec_valid(exec_valid), .exec_cls(exec_cls),
        .exec_opa(exec_opa), .exec_opb(exec_opb), .sys(sys));
    csfu_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .exec_valid(exec_valid), .exec_cls(exec_cls),
        .exec_opa(exec_opa), .exec_opb(exec_opb), .halt_instr(sys[0]),
        .watchdog_refresh_instr(sys[1]), .watchdog_timeout(sys[2]), .exec_result(exec_result),
        .exec_done(exec_done), .flags(flags), .irq(irq));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic step(input logic v, input csfu_cls_t k, input logic [7:0] a,
        input logic [7:0] b, input logic [2:0] sy);
        int bb, ci, sm, r;
        exec_u.op(v, k, a, b, sy);
        r = mf[3];
        if (v && k inside {CSFU_ADD, CSFU_ADD_CARRY, CSFU_SUB, CSFU_SUB_BORROW}) begin
            bb = (k inside {CSFU_SUB, CSFU_SUB_BORROW}) ? 255 - b : b;
            ci = (k inside {CSFU_ADD_CARRY, CSFU_SUB_BORROW}) ? mf[0] : (k == CSFU_SUB);
            sm = a + bb + ci;
            r = ((a % 128 + bb % 128 + ci) > 127) ^ (sm > 255);
            mf[0] = sm > 255;
            mf[1] = (a % 16 + bb % 16 + ci) > 15;
            mres = sm[7:0];
        end
        if (v && k == CSFU_AND) mres = a & b;
        if (v && k == CSFU_OR) mres = a | b;
        if (v && k == CSFU_XOR) mres = a ^ b;
        if (v && k inside {[CSFU_ADD:CSFU_XOR]}) begin
            mf[3] = r;
            mf[2] = mres == 8'h00;
            mf[7] = r ^ mres[7];
            if (k == CSFU_SUB) mf[6] = mf[2];
            if (k == CSFU_SUB_BORROW) mf[6] = mf[6] & mf[2];
        end
        if (v && k == CSFU_RLC) begin
            mres = {a[6:0], mf[0]};
            mf[0] = a[7];
        end
        if (v && k == CSFU_RRC) begin
            mres = {mf[0], a[7:1]};
            mf[0] = a[0];
        end
        if (v && k == CSFU_WRST) mf = (a & 8'hcf) | (mf & 8'h30);
        if (sy[1]) mf[5:4] = 2'b00;
        if (sy[0]) mf[5:4] = 2'b01;
        if (sy[2]) mf[5] = 1'b1;
        #1;
        chk(flags, mf);
        chk(exec_result, mres);
        chk(exec_done, v);
    endtask : step
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #200000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        seed = 15293;
        pstrb = 4'hf;
        mf = 8'h00;
        mres = 8'h00;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h008, 32'h0);
        chk(rd, 32'h0);
        step(1'b1, CSFU_SUB, 8'h05, 8'h05, 3'h0);
        step(1'b1, CSFU_SUB_BORROW, 8'h03, 8'h03, 3'h0);
        step(1'b1, CSFU_ADD, 8'h7f, 8'h01, 3'h0);
        for (int i = 0; i < 400; i++) begin
            s = ($random(seed) % 4 == 0) ? $random(seed) & 7 : 0;
            step(i % 5 != 0, csfu_cls_t'($unsigned($random(seed)) % 11), 8'($random(seed)),
                8'($random(seed)), 3'(s));
        end
        apb(1'b1, 12'h000, 32'hff);
        mf = (mf & 8'h30) | 8'hcf;
        #1 chk(flags, mf);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, {24'h0, mf});
        pstrb <= 4'h0;
        apb(1'b1, 12'h000, 32'h0);
        pstrb <= 4'hf;
        #1 chk(flags, mf);
        apb(1'b0, 12'h00c, 32'h0);
        chk(rd, {24'h0, mres});
        apb(1'b0, 12'h010, 32'h0);
        chk(err, 1'b1);
        chk(rd, 32'h0);
        apb(1'b1, 12'h008, 32'h0);
        apb(1'b0, 12'h004, 32'h0);
        step(1'b0, CSFU_NOP, 8'h00, 8'h00, 3'h4);
        chk(irq, 1'b0);
        apb(1'b1, 12'h008, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b1);
        apb(1'b0, 12'h004, 32'h0);
        chk(rd, 32'h1);
        repeat (2) @(posedge pclk);
        chk(irq, 1'b0);
        report_and_stop();
    end
endmodule : csfu_top_tb
`default_nettype wire
